// *** cim_counter.sv ***
// Behaviour
// - Edge counting starts only after software arms the counter.
// - Source edge polarity for counting is selectable rising or falling.
// - Count register readable any time without disturbing counting.
// - Active pause trigger holds count; inactive pause counts normally.
// - Pause trigger is Gate with selectable pause level.
// - Buffered edge counting pushes count into FIFO on each active sample clock edge.
// - Buffered counts are cumulative from arm; sample clock never clears.
// - Sample clock active edge selectable rising or falling.
// - Buffered edge counting starts at arm, not first sample clock.
// - Direction up, down, or by auxiliary input high up low down.
// - Pulse-width counts Source edges while Gate at selectable active level.
// - Armed during active Gate skips partial pulse, waits next active transition.
// - Single pulse-width pushes count once at Gate end, then ignores inputs.
// - Implicit buffered pulse-width pushes count at every Gate trailing edge.
// - Sampled pulse-width pushes last completed width on each sample clock that follows a newly completed width.
// - Sampled pulse modes flag overrun when no pulse completed since last sample.
// - Pulse mode counts both Gate phases giving high and low counts.
// - Implicit pulse stores high and low at every second Gate edge after selected starting edge.
// - Sampled pulse mode pushes high and low of last completed pulse.
// - Semi-period counts Source edges between consecutive Gate edges.
// - FIFO contents stream continuously to host memory.
// - Counter register is 32 bits wide.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module cim_counter (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic [4:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       src_in,
  input  wire logic                       gate_in,
  input  wire logic                       sclk_in,
  input  wire logic                       dir_in,
  output logic                            st_valid,
  output logic      [cim_pkg::CNT_W-1:0]  st_data,
  input  wire logic                       st_ready
);
  import cim_pkg::*;

  // ==========================================================================
  // Bus slave
  logic [31:0]      avs_readdata_q;
  logic             avs_waitrequest_q;
  logic [10:0]      cfg_q;
  logic [31:0]      init_q;
  logic [31:0]      wmask;
  logic             wr_acc;
  logic             arm_pulse;
  logic             disarm_pulse;
  logic [31:0]      rd_mux;
  logic [31:0]      status_w;
  logic [CNT_W-1:0] cnt_q;
  cim_state_t       st_q;
  logic             overrun_q;
  logic             fifo_ovf_q;
  logic             empty;
  logic             full;
  logic [FIFO_AW:0] level;

  assign avs_readdata    = avs_readdata_q;
  assign avs_waitrequest = avs_waitrequest_q;
  assign wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // Write lands only at the edge where the master sees waitrequest low
  assign wr_acc = avs_write && !avs_waitrequest_q;
  assign arm_pulse    = wr_acc && avs_address == CIM_ADDR_CTRL &&
                        avs_byteenable[0] && avs_writedata[CTRL_ARM_BIT];
  assign disarm_pulse = wr_acc && avs_address == CIM_ADDR_CTRL &&
                        avs_byteenable[0] && avs_writedata[CTRL_DISARM_BIT];

  always_comb begin
    status_w = '0;
    status_w[ST_ARMED_BIT]    = st_q == CIM_ST_WAIT || st_q == CIM_ST_RUN;
    status_w[ST_DONE_BIT]     = st_q == CIM_ST_DONE;
    status_w[ST_OVERRUN_BIT]  = overrun_q;
    status_w[ST_FIFO_OVF_BIT] = fifo_ovf_q;
    status_w[ST_EMPTY_BIT]    = empty;
    status_w[ST_FULL_BIT]     = full;
    status_w[ST_LEVEL_LSB +: FIFO_AW+1] = level;
  end

  always_comb begin
    case (avs_address)
      CIM_ADDR_CFG:    rd_mux = {21'h000000, cfg_q};
      CIM_ADDR_INIT:   rd_mux = init_q;
      CIM_ADDR_COUNT:  rd_mux = cnt_q;
      CIM_ADDR_STATUS: rd_mux = status_w;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access; read data captured without touching the counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_q <= 1'b1;
      avs_readdata_q    <= 32'h0000_0000;
    end else if (!avs_waitrequest_q) begin
      avs_waitrequest_q <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest_q <= 1'b0;
      avs_readdata_q    <= avs_read ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q  <= CFG_RESET;
      init_q <= INIT_RESET;
    end else if (wr_acc) begin
      if (avs_address == CIM_ADDR_CFG)
        cfg_q <= (cfg_q & ~wmask[10:0]) | (avs_writedata[10:0] & wmask[10:0]);
      if (avs_address == CIM_ADDR_INIT)
        init_q <= (init_q & ~wmask) | (avs_writedata & wmask);
    end
  end

  cim_mode_t mode;
  cim_buf_t  bufm;
  cim_dir_t  dirm;
  assign mode = cim_mode_t'(cfg_q[CFG_MODE_LSB +: 2]);
  assign bufm = cim_buf_t'(cfg_q[CFG_BUF_LSB +: 2]);
  assign dirm = cim_dir_t'(cfg_q[CFG_DIR_LSB +: 2]);

  // ==========================================================================
  // Input edge detection
  logic src_prev_q, gate_prev_q, sclk_prev_q;
  logic src_ev, sclk_ev, gate_ev, gate_act, gate_lead, gate_trail, start_ev;
  logic paused, sampled, count_up;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_q  <= 1'b0;
      gate_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      src_prev_q  <= src_in;
      gate_prev_q <= gate_in;
      sclk_prev_q <= sclk_in;
    end
  end

  assign src_ev     = cfg_q[CFG_SRC_FALL] ? (src_prev_q && !src_in)
                                          : (!src_prev_q && src_in);
  assign sclk_ev    = cfg_q[CFG_SCLK_FALL] ? (sclk_prev_q && !sclk_in)
                                           : (!sclk_prev_q && sclk_in);
  assign gate_ev    = gate_prev_q ^ gate_in;
  assign gate_act   = gate_in == cfg_q[CFG_GATE_LVL];
  assign gate_lead  = gate_ev && gate_act;
  assign gate_trail = gate_ev && !gate_act;
  assign start_ev   = gate_ev && (gate_in == cfg_q[CFG_FIRST_HIGH]);
  assign paused     = cfg_q[CFG_PAUSE_EN] &&
                      (gate_in == cfg_q[CFG_GATE_LVL]);
  assign sampled    = bufm == CIM_BUF_SAMP;
  assign count_up   = dirm == CIM_DIR_UP || (dirm == CIM_DIR_EXT && dir_in);

  // ==========================================================================
  // Measurement sequencing
  logic             half_q, have_q;
  logic [CNT_W-1:0] first_q, hi_cnt, lo_cnt, last_w_q, last_hi_q, last_lo_q;
  logic             pw_end, pair_end, armed, samp_mode, samp_push, ovr_set;

  assign armed     = st_q == CIM_ST_WAIT || st_q == CIM_ST_RUN;
  assign pw_end    = st_q == CIM_ST_RUN && mode == CIM_MODE_PW && gate_trail;
  assign pair_end  = st_q == CIM_ST_RUN && mode == CIM_MODE_PULSE && gate_ev && half_q;
  assign hi_cnt    = cfg_q[CFG_FIRST_HIGH] ? first_q : cnt_q;
  assign lo_cnt    = cfg_q[CFG_FIRST_HIGH] ? cnt_q : first_q;
  assign samp_mode = sampled && (mode == CIM_MODE_PW || mode == CIM_MODE_PULSE);
  assign samp_push = samp_mode && armed && sclk_ev && have_q;
  assign ovr_set   = samp_mode && armed && sclk_ev && !have_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= CIM_ST_IDLE;
    end else if (arm_pulse) begin
      // Edge counting runs from the arm itself; measurements wait for Gate
      st_q <= mode == CIM_MODE_EDGE ? CIM_ST_RUN : CIM_ST_WAIT;
    end else if (disarm_pulse) begin
      st_q <= CIM_ST_IDLE;
    end else begin
      case (st_q)
        CIM_ST_WAIT: begin
          if (mode == CIM_MODE_PW ? gate_lead : start_ev)
            st_q <= CIM_ST_RUN;
        end
        CIM_ST_RUN: begin
          if (pw_end)
            st_q <= bufm == CIM_BUF_SINGLE ? CIM_ST_DONE : CIM_ST_WAIT;
          else if (bufm == CIM_BUF_SINGLE && gate_ev &&
                   (mode == CIM_MODE_SEMI || (mode == CIM_MODE_PULSE && half_q)))
            st_q <= CIM_ST_DONE;
        end
        CIM_ST_IDLE, CIM_ST_DONE: st_q <= st_q;
        default:     st_q <= CIM_ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Counter register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (arm_pulse) begin
      cnt_q <= init_q;
    end else if (st_q == CIM_ST_WAIT) begin
      if (mode == CIM_MODE_PW ? gate_lead : start_ev)
        cnt_q <= init_q;
    end else if (st_q == CIM_ST_RUN) begin
      case (mode)
        CIM_MODE_EDGE: begin
          // Sample clock never touches the count, so captures stay cumulative
          if (src_ev && !paused)
            cnt_q <= count_up ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end
        CIM_MODE_PW: begin
          if (gate_act && src_ev)
            cnt_q <= cnt_q + 1'b1;
        end
        default: begin
          if (gate_ev)
            cnt_q <= init_q;
          else if (src_ev)
            cnt_q <= cnt_q + 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_q  <= 1'b0;
      first_q <= '0;
    end else if (arm_pulse || st_q != CIM_ST_RUN) begin
      half_q <= 1'b0;
    end else if (mode == CIM_MODE_PULSE && gate_ev) begin
      half_q <= !half_q;
      if (!half_q)
        first_q <= cnt_q;
    end
  end

  // Latest completed result held for the sample clock; a new result wins over the take
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      have_q    <= 1'b0;
      last_w_q  <= '0;
      last_hi_q <= '0;
      last_lo_q <= '0;
    end else if (arm_pulse) begin
      have_q <= 1'b0;
    end else if (samp_mode && (pw_end || pair_end)) begin
      have_q    <= 1'b1;
      last_w_q  <= cnt_q;
      last_hi_q <= hi_cnt;
      last_lo_q <= lo_cnt;
    end else if (samp_push) begin
      have_q <= 1'b0;
    end
  end

  // ==========================================================================
  // FIFO push selection; a pulse result is two words, high first
  logic [1:0]       push_n;
  logic [CNT_W-1:0] push_d0, push_d1;

  always_comb begin
    push_n  = 2'h0;
    push_d0 = cnt_q;
    push_d1 = cnt_q;
    if (samp_push) begin
      push_n  = mode == CIM_MODE_PULSE ? 2'h2 : 2'h1;
      push_d0 = mode == CIM_MODE_PULSE ? last_hi_q : last_w_q;
      push_d1 = last_lo_q;
    end else if (st_q == CIM_ST_RUN) begin
      case (mode)
        CIM_MODE_EDGE: if (sampled && sclk_ev) push_n = 2'h1;
        CIM_MODE_PW:   if (pw_end && !sampled) push_n = 2'h1;
        CIM_MODE_SEMI: if (gate_ev)            push_n = 2'h1;
        default: begin
          if (pair_end && !sampled) begin
            push_n  = 2'h2;
            push_d0 = hi_cnt;
            push_d1 = lo_cnt;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      overrun_q <= 1'b0;
    else if (ovr_set)
      overrun_q <= 1'b1;
    else if (wr_acc && avs_address == CIM_ADDR_STATUS && avs_byteenable[0] &&
             avs_writedata[ST_OVERRUN_BIT])
      overrun_q <= 1'b0;
  end

  // ==========================================================================
  // Result FIFO and stream to the transfer engine
  logic [CNT_W-1:0] mem_q [FIFO_DEPTH];
  logic [FIFO_AW:0] wr_ptr_q, rd_ptr_q, free;
  logic             push_ok, pop, st_valid_q;
  logic [CNT_W-1:0] st_data_q;

  assign level   = wr_ptr_q - rd_ptr_q;
  assign free    = FIFO_DEPTH_C - level;
  assign empty   = level == '0;
  assign full    = level == FIFO_DEPTH_C;
  // Whole pair or nothing, so high and low never split across an overflow
  assign push_ok = push_n != 2'h0 && free >= {2'h0, push_n};
  assign pop     = !empty && (!st_valid_q || st_ready);
  assign st_valid = st_valid_q;
  assign st_data  = st_data_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
    end else if (push_ok) begin
      mem_q[wr_ptr_q[FIFO_AW-1:0]] <= push_d0;
      if (push_n == 2'h2)
        mem_q[wr_ptr_q[FIFO_AW-1:0] + 1'b1] <= push_d1;
      wr_ptr_q <= wr_ptr_q + {2'h0, push_n};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      fifo_ovf_q <= 1'b0;
    else if (push_n != 2'h0 && !push_ok)
      fifo_ovf_q <= 1'b1;
    else if (wr_acc && avs_address == CIM_ADDR_STATUS && avs_byteenable[0] &&
             avs_writedata[ST_FIFO_OVF_BIT])
      fifo_ovf_q <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q   <= '0;
      st_valid_q <= 1'b0;
      st_data_q  <= '0;
    end else if (pop) begin
      rd_ptr_q   <= rd_ptr_q + 1'b1;
      st_valid_q <= 1'b1;
      st_data_q  <= mem_q[rd_ptr_q[FIFO_AW-1:0]];
    end else if (st_ready) begin
      st_valid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_ARM_LOADS_INIT: assert property (arm_pulse |=> cnt_q == $past(init_q))
    else $error("Arm did not load the initial value");
  AST_IDLE_HOLDS: assert property ((st_q == CIM_ST_IDLE && !arm_pulse) |=> $stable(cnt_q))
    else $error("Count moved while not armed");
  AST_EDGE_STEP: assert property ((st_q == CIM_ST_RUN && mode == CIM_MODE_EDGE && src_ev
    && !paused && !arm_pulse && !disarm_pulse)
    |=> cnt_q == ($past(count_up) ? $past(cnt_q) + 1 : $past(cnt_q) - 1))
    else $error("Edge count step wrong");
  AST_PAUSE_HOLD: assert property ((st_q == CIM_ST_RUN && mode == CIM_MODE_EDGE && paused
    && !arm_pulse) |=> $stable(cnt_q))
    else $error("Count moved while paused");
  AST_SAMPLE_PUSH: assert property ((st_q == CIM_ST_RUN && mode == CIM_MODE_EDGE
    && sampled && sclk_ev) |-> push_n == 2'h1 && push_d0 == cnt_q)
    else $error("Sample clock did not capture the count");
  AST_PW_PUSH: assert property ((pw_end && !sampled) |-> push_n == 2'h1)
    else $error("Trailing Gate edge did not store the width");
  AST_SINGLE_DONE: assert property ((pw_end && bufm == CIM_BUF_SINGLE && !arm_pulse
    && !disarm_pulse) |=> st_q == CIM_ST_DONE [*2])
    else $error("Single pulse-width did not stop");
  AST_OVERRUN: assert property (ovr_set |=> overrun_q)
    else $error("Overrun not flagged");
  AST_PAIR_ONLY_PULSE: assert property (push_n == 2'h2 |-> mode == CIM_MODE_PULSE)
    else $error("Paired push outside pulse mode");
  AST_STREAM_HOLD: assert property ((st_valid_q && !st_ready)
    |=> st_valid_q && $stable(st_data_q))
    else $error("Stream word dropped under back-pressure");
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest_q)
    else $error("Bus access not answered");

  COV_EDGE_SAMPLED: cover property (st_q == CIM_ST_RUN && mode == CIM_MODE_EDGE && push_ok);
  COV_PULSE_PAIR: cover property (push_ok && push_n == 2'h2);
  COV_OVERRUN: cover property (ovr_set);
  COV_SINGLE_DONE: cover property (st_q == CIM_ST_DONE);

endmodule // cim_counter

// *** cim_pkg.sv ***
package cim_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [4:0] CIM_ADDR_CTRL   = 5'h00;
  localparam logic [4:0] CIM_ADDR_CFG    = 5'h04;
  localparam logic [4:0] CIM_ADDR_INIT   = 5'h08;
  localparam logic [4:0] CIM_ADDR_COUNT  = 5'h0c;
  localparam logic [4:0] CIM_ADDR_STATUS = 5'h10;

  // ==========================================================================
  // Field positions
  localparam int CTRL_ARM_BIT    = 0;
  localparam int CTRL_DISARM_BIT = 1;
  localparam int CFG_MODE_LSB    = 0;
  localparam int CFG_BUF_LSB     = 2;
  localparam int CFG_SRC_FALL    = 4;
  localparam int CFG_GATE_LVL    = 5;
  localparam int CFG_SCLK_FALL   = 6;
  localparam int CFG_PAUSE_EN    = 7;
  localparam int CFG_DIR_LSB     = 8;
  localparam int CFG_FIRST_HIGH  = 10;
  localparam int ST_ARMED_BIT    = 0;
  localparam int ST_DONE_BIT     = 1;
  localparam int ST_OVERRUN_BIT  = 2;
  localparam int ST_FIFO_OVF_BIT = 3;
  localparam int ST_EMPTY_BIT    = 4;
  localparam int ST_FULL_BIT     = 5;
  localparam int ST_LEVEL_LSB    = 8;

  // ==========================================================================
  // Reset values and sizes
  localparam int          CNT_W         = 32;
  localparam logic [10:0] CFG_RESET     = 11'h000;
  localparam logic [31:0] INIT_RESET    = 32'h0000_0000;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          FIFO_AW       = 3;
  localparam logic [FIFO_AW:0] FIFO_DEPTH_C = 4'h8;

  typedef enum logic [1:0] {
    CIM_MODE_EDGE  = 2'h0,
    CIM_MODE_PW    = 2'h1,
    CIM_MODE_PULSE = 2'h2,
    CIM_MODE_SEMI  = 2'h3
  } cim_mode_t;

  typedef enum logic [1:0] {
    CIM_BUF_SINGLE = 2'h0,
    CIM_BUF_IMPL   = 2'h1,
    CIM_BUF_SAMP   = 2'h2
  } cim_buf_t;

  typedef enum logic [1:0] {
    CIM_DIR_UP   = 2'h0,
    CIM_DIR_DOWN = 2'h1,
    CIM_DIR_EXT  = 2'h2
  } cim_dir_t;

  // Gray order along idle -> wait -> run -> done
  typedef enum logic [1:0] {
    CIM_ST_IDLE = 2'h0,
    CIM_ST_WAIT = 2'h1,
    CIM_ST_RUN  = 2'h3,
    CIM_ST_DONE = 2'h2
  } cim_state_t;

endpackage

// *** cim_far_end.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Far-side model: Source, Gate, sample clock and direction lines
module cim_far_end (
  input  wire logic ref_clk,
  output logic      src_in,
  output logic      gate_in,
  output logic      sclk_in,
  output logic      dir_in
);
  initial begin
    src_in  = 1'b0;
    gate_in = 1'b0;
    sclk_in = 1'b0;
    dir_in  = 1'b1;
  end

  // High stands two cycles and low at least two, so no Source edge lands on a Gate edge
  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge ref_clk);
      src_in <= 1'b1;
      repeat (2) @(posedge ref_clk);
      src_in <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask

  task automatic set_gate(input logic v);
    @(posedge ref_clk);
    gate_in <= v;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic set_dir(input logic v);
    @(posedge ref_clk);
    dir_in <= v;
  endtask

  task automatic set_sclk(input logic v);
    @(posedge ref_clk);
    sclk_in <= v;
    repeat (2) @(posedge ref_clk);
  endtask

  // One full sample clock period: a rising and a falling edge
  task automatic tick();
    set_sclk(1'b1);
    set_sclk(1'b0);
  endtask
endmodule // cim_far_end

// *** tb.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the counter-input block
module tb;
  import cim_pkg::*;
  localparam logic [31:0] GL = 32'h1 << CFG_GATE_LVL;
  localparam logic [31:0] FH = 32'h1 << CFG_FIRST_HIGH;
  localparam logic [31:0] OV = 32'h1 << ST_OVERRUN_BIT;
  logic        ref_clk;
  logic        rst_n;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        src_in;
  logic        gate_in;
  logic        sclk_in;
  logic        dir_in;
  logic        st_valid;
  logic [31:0] st_data;
  logic        st_ready;
  logic [3:0]  avs_byteenable;
  logic [3:0]  lanes;
  logic [15:0] rs = 16'h0028;
  logic [31:0] words[$];
  logic [15:0] rnd;
  logic [31:0] ini;
  int          n;
  int          error_cnt;
  int          samples_checked;

  cim_far_end i_far (.ref_clk(ref_clk), .src_in(src_in), .gate_in(gate_in),
                     .sclk_in(sclk_in), .dir_in(dir_in));
  cim_counter i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_in(src_in), .gate_in(gate_in),
    .sclk_in(sclk_in), .dir_in(dir_in), .st_valid(st_valid), .st_data(st_data),
    .st_ready(st_ready));

  // Stream sink; the transfer engine stalls at random to load back-pressure
  always @(posedge ref_clk) begin
    if (st_valid === 1'b1 && st_ready === 1'b1) words.push_back(st_data);
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  always @(posedge ref_clk) begin
    rs       <= lfsr(rs);
    st_ready <= rs[0] | rs[1];
  end

  function automatic logic [31:0] mk(input logic [1:0] m, b, d, input logic [31:0] fl);
    return (32'(m) << CFG_MODE_LSB) | (32'(b) << CFG_BUF_LSB) | (32'(d) << CFG_DIR_LSB) | fl;
  endfunction

  function automatic logic [31:0] ecnt(input logic [31:0] i, input int k, d, input logic up);
    return (d == 0 || (d == 2 && up)) ? i + 32'(k) : i - 32'(k);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic expire();
    error_cnt++;
    $display("Error at %0t: wait expired", $time);
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_byteenable <= lanes;
    avs_write     <= w;
    avs_read      <= ~w;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) expire();
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdm(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic expw(input logic [31:0] e);
    int k;
    k = 0;
    while (words.size() == 0 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    if (words.size() == 0) expire();
    chk(words.pop_front(), e);
  endtask

  // Disarm, let the stream drain, then configure and arm
  task automatic arm(input logic [31:0] c, input logic [31:0] i);
    wr(CIM_ADDR_CTRL, 32'h2);
    repeat (12) @(posedge ref_clk);
    words.delete();
    wr(CIM_ADDR_CFG, c);
    wr(CIM_ADDR_INIT, i);
    wr(CIM_ADDR_CTRL, 32'h1);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    lanes = 4'hf;
    error_cnt = 0;
    samples_checked = 0;
    rnd = 16'h0028;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdm(CIM_ADDR_CFG, 32'hffff_ffff, 32'h0);
    rdm(CIM_ADDR_INIT, 32'hffff_ffff, 32'h0);
    rdm(5'h14, 32'hffff_ffff, 32'h0);
    lanes = 4'h5;
    wr(CIM_ADDR_INIT, 32'haabb_ccdd);
    lanes = 4'hf;
    rdm(CIM_ADDR_INIT, 32'hffff_ffff, 32'h00bb_00dd);
    i_far.pulses(2);
    rdm(CIM_ADDR_COUNT, 32'hffff_ffff, 32'h0);
    for (int d = 0; d < 3; d++) begin
      for (int f = 0; f < 2; f++) begin
        rnd = lfsr(rnd);
        n   = int'(rnd[2:0]) + 1;
        ini = (d == 0 && f == 0) ? 32'hffff_ffff : {rnd, ~rnd};
        i_far.set_dir(rnd[3]);
        arm(mk(CIM_MODE_EDGE, CIM_BUF_SINGLE, 2'(d), 32'(f) << CFG_SRC_FALL), ini);
        i_far.pulses(n);
        rdm(CIM_ADDR_COUNT, 32'hffff_ffff, ecnt(ini, n, d, rnd[3]));
        i_far.pulses(n);
        rdm(CIM_ADDR_COUNT, 32'hffff_ffff, ecnt(ini, 2 * n, d, rnd[3]));
      end
    end
    for (int p = 0; p < 2; p++) begin
      arm(mk(CIM_MODE_EDGE, CIM_BUF_SINGLE, 2'h0,
             (p != 0 ? GL : 32'h0) | (32'h1 << CFG_PAUSE_EN)), ini);
      i_far.set_gate(1'(p));
      i_far.pulses(4);
      i_far.set_gate(1'(1 - p));
      i_far.pulses(2);
      i_far.set_gate(1'b0);
      rdm(CIM_ADDR_COUNT, 32'hffff_ffff, ini + 32'h2);
    end
    for (int f = 0; f < 2; f++) begin
      arm(mk(CIM_MODE_EDGE, CIM_BUF_SAMP, 2'h0, 32'(f) << CFG_SCLK_FALL), ini);
      i_far.pulses(3);
      i_far.set_sclk(1'b1);
      i_far.pulses(2);
      i_far.set_sclk(1'b0);
      i_far.pulses(1);
      i_far.tick();
      expw(f != 0 ? ini + 32'h5 : ini + 32'h3);
      expw(ini + 32'h6);
    end
    i_far.set_gate(1'b1);
    arm(mk(CIM_MODE_PW, CIM_BUF_IMPL, 2'h0, GL), ini);
    i_far.pulses(2);
    i_far.set_gate(1'b0);
    for (int k = 1; k < 4; k++) begin
      i_far.set_gate(1'b1);
      i_far.pulses(k);
      i_far.set_gate(1'b0);
      expw(ini + 32'(k));
    end
    arm(mk(CIM_MODE_PW, CIM_BUF_SINGLE, 2'h0, GL), ini);
    for (int k = 2; k < 4; k++) begin
      i_far.set_gate(1'b1);
      i_far.pulses(k);
      i_far.set_gate(1'b0);
    end
    expw(ini + 32'h2);
    repeat (20) @(posedge ref_clk);
    chk(32'(words.size()), 32'h0);
    arm(mk(CIM_MODE_PW, CIM_BUF_SAMP, 2'h0, GL), ini);
    wr(CIM_ADDR_STATUS, OV);
    i_far.tick();
    rdm(CIM_ADDR_STATUS, OV, OV);
    i_far.set_gate(1'b1);
    i_far.pulses(4);
    i_far.set_gate(1'b0);
    i_far.tick();
    expw(ini + 32'h4);
    for (int b = 1; b < 3; b++) begin
      arm(mk(CIM_MODE_PULSE, 2'(b), 2'h0, FH), ini);
      i_far.set_gate(1'b1);
      i_far.pulses(2);
      i_far.set_gate(1'b0);
      i_far.pulses(1);
      i_far.set_gate(1'b1);
      if (b == 2) i_far.tick();
      expw(ini + 32'h2);
      expw(ini + 32'h1);
      i_far.set_gate(1'b0);
    end
    // Low phase first: the rising Gate edge after arming must be skipped
    arm(mk(CIM_MODE_PULSE, CIM_BUF_IMPL, 2'h0, 32'h0), ini);
    i_far.set_gate(1'b1);
    i_far.set_gate(1'b0);
    i_far.pulses(3);
    i_far.set_gate(1'b1);
    i_far.pulses(1);
    i_far.set_gate(1'b0);
    expw(ini + 32'h1);
    expw(ini + 32'h3);
    arm(mk(CIM_MODE_SEMI, CIM_BUF_IMPL, 2'h0, FH), ini);
    i_far.set_gate(1'b1);
    i_far.pulses(2);
    i_far.set_gate(1'b0);
    i_far.pulses(3);
    i_far.set_gate(1'b1);
    expw(ini + 32'h2);
    expw(ini + 32'h3);
    report_and_stop();
  end
endmodule // tb
